// ==== rtl/seb_pkg.sv ====
// Shared constants for the signal edge scaler bank
package seb_pkg;
    // ****************************************************************
    // Register map (byte offsets)
    // ****************************************************************
    localparam logic [15:0] SEB_START_OFS = 16'h008C;
    localparam logic [15:0] SEB_DONE_OFS = 16'h0090;
    localparam logic [15:0] SEB_LATCH_OFS = 16'h0100;
    localparam logic [15:0] SEB_ARRAY_OFS = 16'h0104;
    localparam int SEB_FREEZE_BIT = 0;
    localparam int SEB_DONE_BIT = 0;
    localparam logic SEB_LATCH_RST = 1'b0;

    // ****************************************************************
    // Counter array layout
    // ****************************************************************
    localparam int SEB_CNT_W = 32;
    localparam int SEB_NUM_CNT = 35;
    localparam logic [31:0] SEB_CNT_MAX = 32'hFFFFFFFF;
    localparam logic [31:0] SEB_CNT_RST = 32'h00000000;
    localparam int SEB_IDX_SYS = 0;
    localparam int SEB_IDX_GCLK = 1;
    localparam int SEB_IDX_FIRST_PIN = 2;
    localparam int SEB_IDX_LAST_FRONT = 16;
    localparam int SEB_IDX_BUSY_RISE = 17;
    localparam int SEB_IDX_BUSY_TIME = 18;
    localparam int SEB_IDX_FIRST_REAR = 19;

    // ****************************************************************
    // Synchronised pin vector layout
    // ****************************************************************
    localparam int SEB_PIN_BUSY = 15;
    localparam int SEB_PIN_GCLK = 32;
    localparam int SEB_PIN_NUM = 33;
    localparam int SEB_GCLK_DIV_LOG2 = 6;
endpackage : seb_pkg

// ==== rtl/seb_gclk_tick.sv ====
// Global clock prescaler producing a slow toggle for crossing
`timescale 1ns/1ps
`default_nettype none
module seb_gclk_tick #(
    parameter int DIV_LOG2 = 6
) (
    // Global clock domain
    input wire logic gclk,
    input wire logic nrst,
    // Toggles once per 2**DIV_LOG2 global clock cycles
    output logic tickToggle
);
    logic [DIV_LOG2-1:0] prescale;

    // Free-running prescaler; a stopped clock simply freezes the toggle
    always_ff @(posedge gclk or negedge nrst) begin
        if (!nrst) begin
            prescale <= '0;
            tickToggle <= 1'b0;
        end else begin
            prescale <= prescale + 1'b1;
            if (&prescale) begin
                tickToggle <= ~tickToggle;
            end
        end
    end
endmodule : seb_gclk_tick
`default_nettype wire

// ==== rtl/seb_edge_sync.sv ====
// Three-stage synchroniser bank with level and change outputs
`timescale 1ns/1ps
`default_nettype none
module seb_edge_sync #(
    parameter int WIDTH = 33
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Asynchronous inputs
    input wire logic [WIDTH-1:0] pinIn,
    // Filtered level and one-cycle change pulse
    output logic [WIDTH-1:0] pinLevel,
    output logic [WIDTH-1:0] pinChange
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // Shift chain; stage1 feeds only stage2
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A change counts only once stage2 and stage3 agree
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pinLevel <= '0;
            pinChange <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                pinChange[i] <= (stage2[i] == stage3[i]) && (stage3[i] != pinLevel[i]);
                if (stage2[i] == stage3[i]) begin
                    pinLevel[i] <= stage3[i];
                end
            end
        end
    end
endmodule : seb_edge_sync
`default_nettype wire

// ==== rtl/seb_scaler_bank.sv ====
// Scaler bank top: pin synchronisers, 35 saturating counters, registers
//
// Behaviour
// RULE1 - Done bit reads 0 while pulser runs
// RULE2 - Freeze bit set stops all counters
// RULE3 - Freeze bit cleared zeroes counters, resumes counting
// RULE4 - Freeze register resets to zero, counters run
// RULE5 - 32-bit read-only counters saturate at all ones
// RULE6 - Counter array word per index from 0x0104
// RULE7 - Index 0 counts system clock cycles
// RULE8 - Index 1 counts global clock, tolerates absence
// RULE9 - Indices 2-4 count backplane sync, trigger edges
// RULE10 - Indices 5-6 count front NIM output edges
// RULE11 - Indices 7-11 count front diff input edges
// RULE12 - Indices 12-16 count front diff output edges
// RULE13 - Index 17 counts busy assertions
// RULE14 - Index 18 counts cycles busy is high
// RULE15 - Indices 19-26 count rear diff input edges
// RULE16 - Indices 27-34 count rear diff output edges
// RULE17 - Software starts pulser run via start register
// RULE18 - Edge is synchronised rising transition, counted once
// RULE19 - Global clock count crosses domains safely
`timescale 1ns/1ps
`default_nettype none
module seb_scaler_bank #(
    parameter int GCLK_DIV_LOG2 = seb_pkg::SEB_GCLK_DIV_LOG2
) (
    // Clocks and reset
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic gclk,
    // Register port
    input wire logic [15:0] regAddr,
    input wire logic regWrEn,
    input wire logic [31:0] regWrData,
    input wire logic regRdEn,
    output logic [31:0] regRdData,
    output logic regRdValid,
    // Pulser status and start strobe
    input wire logic pulserActive,
    output logic pulseRunTrigger,
    // Backplane inputs
    input wire logic backplaneSync,
    input wire logic backplaneTrigA,
    input wire logic backplaneTrigB,
    // Front panel signals
    input wire logic [1:0] frontNimOut,
    input wire logic [4:0] frontDiffIn,
    input wire logic [4:0] frontDiffOut,
    // Event builder busy
    input wire logic busy,
    // Rear connector signals
    input wire logic [7:0] rearDiffIn,
    input wire logic [7:0] rearDiffOut
);
    import seb_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // Toggle must stay slower than four system cycles at 250/20 MHz
    if (GCLK_DIV_LOG2 < 6 || GCLK_DIV_LOG2 > 16) begin : g_bad_div
        $error("GCLK_DIV_LOG2 out of range 6..16");
    end

    localparam logic [31:0] GCLK_STEP = 32'(1) << GCLK_DIV_LOG2;

    logic gclkToggle;
    logic [SEB_PIN_NUM-1:0] pinVec;
    logic [SEB_PIN_NUM-1:0] pinLevel;
    logic [SEB_PIN_NUM-1:0] pinChange;
    logic [SEB_PIN_NUM-1:0] pinRise;
    logic latchFreeze;
    logic clearAll;
    logic latchWrite;
    logic [31:0] cnt [SEB_NUM_CNT];
    logic [31:0] step [SEB_NUM_CNT];
    logic [31:0] rdMux;
    logic [15:0] arrayOffs;
    logic [13:0] arrayIdx;
    logic arrayHit;

    // ****************************************************************
    // Global clock crossing
    // ****************************************************************
    // Slow toggle crosses by synchroniser; resolution traded for safety
    seb_gclk_tick #(
        .DIV_LOG2(GCLK_DIV_LOG2)
    ) u_gclk_tick (
        .gclk(gclk),
        .nrst(nrst),
        .tickToggle(gclkToggle)
    ); // RULE19

    // Pin vector: backplane, front, busy, rear, global toggle
    assign pinVec = {gclkToggle, rearDiffOut, rearDiffIn, busy, frontDiffOut,
                     frontDiffIn, frontNimOut, backplaneTrigB, backplaneTrigA,
                     backplaneSync};

    seb_edge_sync #(
        .WIDTH(SEB_PIN_NUM)
    ) u_edge_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pinIn(pinVec),
        .pinLevel(pinLevel),
        .pinChange(pinChange)
    );

    // Rising edge: a settled change to high, one cycle only
    assign pinRise = pinChange & pinLevel; // RULE18

    // ****************************************************************
    // Freeze control
    // ****************************************************************
    assign latchWrite = regWrEn && (regAddr == SEB_LATCH_OFS);
    // Clearing happens only on the freeze to run transition
    assign clearAll = latchWrite && !regWrData[SEB_FREEZE_BIT] && latchFreeze; // RULE3

    // Freeze register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            latchFreeze <= SEB_LATCH_RST; // RULE4
        end else if (latchWrite) begin
            latchFreeze <= regWrData[SEB_FREEZE_BIT]; // RULE2
        end
    end

    // ****************************************************************
    // Counter increments
    // ****************************************************************
    generate
        for (genvar i = 0; i < SEB_NUM_CNT; i++) begin : g_step
            if (i == SEB_IDX_SYS) begin : g_sys
                assign step[i] = 32'h00000001; // RULE7
            end else if (i == SEB_IDX_GCLK) begin : g_gclk
                // No global clock means no toggle, so no step
                assign step[i] = pinChange[SEB_PIN_GCLK] ? GCLK_STEP : 32'h00000000; // RULE8
            end else if (i <= SEB_IDX_LAST_FRONT) begin : g_front
                assign step[i] = {31'h00000000, pinRise[i-SEB_IDX_FIRST_PIN]}; // RULE9 RULE10 RULE11 RULE12
            end else if (i == SEB_IDX_BUSY_RISE) begin : g_busy
                assign step[i] = {31'h00000000, pinRise[SEB_PIN_BUSY]}; // RULE13
            end else if (i == SEB_IDX_BUSY_TIME) begin : g_busyt
                assign step[i] = {31'h00000000, pinLevel[SEB_PIN_BUSY]}; // RULE14
            end else begin : g_rear
                assign step[i] = {31'h00000000, pinRise[i-SEB_IDX_FIRST_REAR+16]}; // RULE15 RULE16
            end
        end
    endgenerate

    // ****************************************************************
    // Saturating counters
    // ****************************************************************
    generate
        for (genvar i = 0; i < SEB_NUM_CNT; i++) begin : g_cnt
            logic [32:0] sum;
            assign sum = {1'b0, cnt[i]} + {1'b0, step[i]};
            // Sticks at all ones so software can see overflow
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    cnt[i] <= SEB_CNT_RST;
                end else if (clearAll) begin
                    cnt[i] <= SEB_CNT_RST; // RULE3
                end else if (!latchFreeze) begin
                    cnt[i] <= sum[32] ? SEB_CNT_MAX : sum[31:0]; // RULE2 RULE5
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Register read path
    // ****************************************************************
    assign arrayOffs = regAddr - SEB_ARRAY_OFS;
    assign arrayIdx = arrayOffs[15:2];
    assign arrayHit = (regAddr >= SEB_ARRAY_OFS) && (arrayOffs[1:0] == 2'b00)
                      && (arrayIdx < 14'(SEB_NUM_CNT)); // RULE6

    // Unmapped addresses read as zero
    always_comb begin
        rdMux = 32'h00000000;
        if (arrayHit) begin
            rdMux = cnt[arrayIdx[5:0]]; // RULE6
        end else if (regAddr == SEB_LATCH_OFS) begin
            rdMux[SEB_FREEZE_BIT] = latchFreeze;
        end else if (regAddr == SEB_DONE_OFS) begin
            rdMux[SEB_DONE_BIT] = !pulserActive; // RULE1
        end
    end

    // Read data one cycle after the read strobe
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            regRdData <= 32'h00000000;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                regRdData <= rdMux;
            end
        end
    end

    // Any write to the start register launches a pulser run
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pulseRunTrigger <= 1'b0;
        end else begin
            pulseRunTrigger <= regWrEn && (regAddr == SEB_START_OFS); // RULE17
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    AST_DONE_READ: assert property ( // RULE1
        regRdEn && regAddr == SEB_DONE_OFS |=> regRdData[0] == !$past(pulserActive))
        else $error("done bit does not mirror pulser activity");

    AST_FREEZE_HOLD: assert property ( // RULE2
        latchFreeze && !clearAll |=> cnt[0] == $past(cnt[0]) && cnt[18] == $past(cnt[18]))
        else $error("counter moved while frozen");

    AST_CLEAR_ZERO: assert property ( // RULE3
        clearAll |=> cnt[0] == 32'h00000000 && cnt[17] == 32'h00000000 && !latchFreeze)
        else $error("counters not cleared on unfreeze");

    AST_SATURATE: assert property ( // RULE5
        cnt[2] == SEB_CNT_MAX && !clearAll |=> cnt[2] == SEB_CNT_MAX)
        else $error("counter wrapped past all ones");

    AST_ARRAY_READ: assert property ( // RULE6
        regRdEn && regAddr == 16'h010C |=> regRdData == $past(cnt[2]))
        else $error("array index 2 read wrong value");

    AST_SYS_COUNT: assert property ( // RULE7
        !latchFreeze && !clearAll && cnt[0] != SEB_CNT_MAX |=> cnt[0] == $past(cnt[0]) + 32'h1)
        else $error("system cycle counter missed a cycle");

    AST_GCLK_STEP: assert property ( // RULE8
        !latchFreeze && !clearAll && pinChange[SEB_PIN_GCLK] && cnt[1] < 32'hFFFF0000
        |=> cnt[1] == $past(cnt[1]) + GCLK_STEP)
        else $error("global clock step not added");

    AST_BUSY_RISE: assert property ( // RULE13
        !latchFreeze && !clearAll && pinRise[SEB_PIN_BUSY] && cnt[17] != SEB_CNT_MAX
        |=> cnt[17] == $past(cnt[17]) + 32'h1)
        else $error("busy assertion not counted");

    AST_BUSY_TIME: assert property ( // RULE14
        !latchFreeze && !clearAll && !pinLevel[SEB_PIN_BUSY] |=> cnt[18] == $past(cnt[18]))
        else $error("busy time counted while idle");

    AST_EDGE_ONCE: assert property ( // RULE18
        pinRise[0] |=> !pinRise[0] ##1 !pinRise[0])
        else $error("single sync edge counted twice");

    // A wrap would show as a counter stepping backwards
    AST_NO_WRAP: assert property ( // RULE5
        !clearAll |=> cnt[1] >= $past(cnt[1]) && cnt[18] >= $past(cnt[18]))
        else $error("counter stepped backwards");

    AST_RESUME: assert property ( // RULE3
        clearAll |-> ##2 cnt[0] == 32'h00000001)
        else $error("counting did not resume after clear");

    AST_TRIG_EDGE: assert property ( // RULE9
        !latchFreeze && !clearAll && pinRise[1] && cnt[3] != SEB_CNT_MAX
        |=> cnt[3] == $past(cnt[3]) + 32'h1)
        else $error("trigger edge not counted");

    AST_NIM_EDGE: assert property ( // RULE10
        !latchFreeze && !clearAll && pinRise[3] && cnt[5] != SEB_CNT_MAX
        |=> cnt[5] == $past(cnt[5]) + 32'h1)
        else $error("NIM output edge not counted");

    AST_FDIN_EDGE: assert property ( // RULE11
        !latchFreeze && !clearAll && pinRise[5] && cnt[7] != SEB_CNT_MAX
        |=> cnt[7] == $past(cnt[7]) + 32'h1)
        else $error("front input edge not counted");

    AST_FDOUT_EDGE: assert property ( // RULE12
        !latchFreeze && !clearAll && pinRise[10] && cnt[12] != SEB_CNT_MAX
        |=> cnt[12] == $past(cnt[12]) + 32'h1)
        else $error("front output edge not counted");

    AST_RDIN_EDGE: assert property ( // RULE15
        !latchFreeze && !clearAll && pinRise[16] && cnt[19] != SEB_CNT_MAX
        |=> cnt[19] == $past(cnt[19]) + 32'h1)
        else $error("rear input edge not counted");

    AST_RDOUT_EDGE: assert property ( // RULE16
        !latchFreeze && !clearAll && pinRise[31] && cnt[34] != SEB_CNT_MAX
        |=> cnt[34] == $past(cnt[34]) + 32'h1)
        else $error("rear output edge not counted");

    AST_RD_VALID: assert property ( // RULE6
        regRdEn |=> regRdValid)
        else $error("read valid missing after read strobe");

    AST_START_PULSE: assert property ( // RULE17
        regWrEn && regAddr == SEB_START_OFS |=> pulseRunTrigger)
        else $error("start write gave no pulse");

    AST_START_ONLY: assert property ( // RULE17
        pulseRunTrigger |-> $past(regWrEn) && $past(regAddr) == SEB_START_OFS)
        else $error("start pulse without start write");

    COV_FREEZE: cover property (latchWrite && regWrData[0] && !latchFreeze);
    COV_CLEAR: cover property (clearAll);
    COV_GCLK: cover property (pinChange[SEB_PIN_GCLK] && !latchFreeze);
    COV_BUSY: cover property (pinRise[SEB_PIN_BUSY] ##[1:20] !pinLevel[SEB_PIN_BUSY]);
endmodule : seb_scaler_bank
`default_nettype wire

// ==== rtl/seb_dummy_unused.sv ====
// Reserved design file; holds no design units
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the signal edge scaler bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import seb_pkg::*;
    // ****
    // Stimulus, clocks and model state
    // ****
    logic ref_clk = 1'b0;
    logic gclk = 1'b0;
    logic gclkOn = 1'b1;
    logic nrst = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic regWrEn = 1'b0;
    logic [31:0] regWrData = 32'h00000000;
    logic regRdEn = 1'b0;
    logic pulserActive = 1'b0;
    logic [34:0] pins = '0;
    wire [31:0] regRdData;
    wire regRdValid;
    wire pulseRunTrigger;
    integer err_count = 0;
    integer cmp_count = 0;
    integer seed = 32'h73A0360F;
    integer cnt [0:34];
    integer i;
    logic [31:0] rdv;

    // Clocks; the global clock is off-phase and can be stopped
    always #25 ref_clk = ~ref_clk;
    always #2.1 gclk = gclkOn ? ~gclk : gclk;

    // Pins are indexed by the counter that watches them
    seb_scaler_bank #(.GCLK_DIV_LOG2(6)) u_seb_scaler_bank (
        .ref_clk(ref_clk), .nrst(nrst), .gclk(gclk),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
        .pulserActive(pulserActive), .pulseRunTrigger(pulseRunTrigger),
        .backplaneSync(pins[2]), .backplaneTrigA(pins[3]), .backplaneTrigB(pins[4]),
        .frontNimOut(pins[6:5]), .frontDiffIn(pins[11:7]), .frontDiffOut(pins[16:12]),
        .busy(pins[17]), .rearDiffIn(pins[26:19]), .rearDiffOut(pins[34:27])
    );

    // ****
    // Shared tasks
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    // Write strobe held one cycle; returns at the edge that takes it
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        // Valid stands one cycle only, so look before the next edge
        @(negedge ref_clk);
        chk({31'b0, regRdValid}, 32'h1, "read valid");
        d = regRdData;
        @(posedge ref_clk);
    endtask : rd

    // Random pin levels held 3 cycles so the synchroniser sees each one
    task automatic drive(input integer n, input logic live);
        logic [34:0] v;
        for (int s = 0; s < n; s++) begin
            v = {3'($random(seed)), 32'($random(seed))};
            v[1:0] = 2'b00;
            v[18] = 1'b0;
            for (int k = 2; k < 35; k++) begin
                if (live && v[k] && !pins[k]) cnt[k]++;
            end
            if (live && v[17]) cnt[18] += 3;
            pins <= v;
            repeat (3) @(posedge ref_clk);
        end
        pins <= '0;
        repeat (10) @(posedge ref_clk);
    endtask : drive

    // Compare every counter with the model; k is the tick count held by the freeze
    task automatic check_all(input integer k);
        logic [31:0] d;
        integer g;
        g = (k * 500) / 42;
        rd(SEB_ARRAY_OFS, d);
        chk(d, 32'(k), "system ticks");
        rd(SEB_ARRAY_OFS + 16'h0004, d);
        chk({31'b0, d[5:0] == 6'h00 && int'(d) <= g + 64 && int'(d) + 384 >= g},
            32'h1, "global ticks");
        for (int j = 2; j < SEB_NUM_CNT; j++) begin
            rd(SEB_ARRAY_OFS + 16'(4 * j), d);
            chk(d, 32'(cnt[j]), "pin counter");
        end
    endtask : check_all

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        #2_000_000;
        err_count++;
        conclude();
    end

    // ****
    // Main sequence
    // ****
    initial begin
        for (i = 0; i < 35; i++) cnt[i] = 0;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(SEB_LATCH_OFS, rdv);
        chk(rdv, 32'h0, "latch reset");
        $display("test reset done");
        // Done bit follows the pulser, start write gives one pulse
        for (i = 0; i < 2; i++) begin
            pulserActive <= i[0];
            rd(SEB_DONE_OFS, rdv);
            chk(rdv, {31'b0, ~i[0]}, "done bit");
        end
        wr(SEB_START_OFS, $random(seed));
        @(negedge ref_clk);
        chk({31'b0, pulseRunTrigger}, 32'h1, "start pulse");
        @(posedge ref_clk);
        pulserActive <= 1'b0;
        @(negedge ref_clk);
        chk({31'b0, pulseRunTrigger}, 32'h0, "start pulse end");
        $display("test pulser done");
        // Clear, count, freeze, lose frozen edges, then read all
        wr(SEB_LATCH_OFS, 32'h1);
        wr(SEB_LATCH_OFS, 32'h0);
        drive(40, 1'b1);
        wr(SEB_LATCH_OFS, 32'h1);
        rd(SEB_LATCH_OFS, rdv);
        chk(rdv, 32'h1, "latch set");
        drive(4, 1'b0);
        wr(SEB_ARRAY_OFS + 16'h0008, 32'h00000055);
        wr(16'h0200, 32'h000000AA);
        // Ticks: driven steps, idle flush, and both edges of the freeze write
        check_all(3 * 40 + 12);
        $display("test counting done");
        // Unmapped, misaligned and past-the-end reads give zero
        rd(16'h0200, rdv);
        chk(rdv, 32'h0, "unmapped");
        rd(SEB_ARRAY_OFS + 16'h0002, rdv);
        chk(rdv, 32'h0, "misaligned");
        rd(SEB_ARRAY_OFS + 16'(4 * SEB_NUM_CNT), rdv);
        chk(rdv, 32'h0, "past end");
        // Unfreeze clears everything
        wr(SEB_LATCH_OFS, 32'h0);
        // The read lands one edge after the clear, so one tick shows
        rd(SEB_ARRAY_OFS, rdv);
        chk(rdv, 32'h1, "cleared ticks");
        rd(SEB_ARRAY_OFS + 16'h0008, rdv);
        chk(rdv, 32'h0, "cleared pins");
        $display("test clear done");
        // Stopped global clock leaves its counter unchanged
        gclkOn <= 1'b0;
        repeat (10) @(posedge ref_clk);
        wr(SEB_LATCH_OFS, 32'h1);
        wr(SEB_LATCH_OFS, 32'h0);
        repeat (20) @(posedge ref_clk);
        wr(SEB_LATCH_OFS, 32'h1);
        rd(SEB_ARRAY_OFS + 16'h0004, rdv);
        chk(rdv, 32'h0, "absent global clock");
        gclkOn <= 1'b1;
        $display("test global clock done");
        // Reset in mid-run while frozen
        nrst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(SEB_LATCH_OFS, rdv);
        chk(rdv, 32'h0, "latch after reset");
        // Counting starts at the first edge after release
        rd(SEB_ARRAY_OFS, rdv);
        chk(rdv, 32'h4, "ticks after reset");
        $display("test second reset done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
